// [logic/mcps_consts.svh]
// constants for the module-carrier power sequencer
// assumes a 25 MHz system clock and a 32-bit classic Wishbone register port
`ifndef MCPS_CONSTS_SVH
`define MCPS_CONSTS_SVH

`define MCPS_CLK_HZ 25000000
`define MCPS_CYC_PER_MS (`MCPS_CLK_HZ / 1000)

// carrier enable to carrier reset release, least time
`define MCPS_PWR_TO_RST_MS 100
`define MCPS_PWR_TO_RST_CYC (((`MCPS_PWR_TO_RST_MS * `MCPS_CYC_PER_MS) > 0) ? \
    (`MCPS_PWR_TO_RST_MS * `MCPS_CYC_PER_MS) : 1)
// reset stretch after reset input release, least time
`define MCPS_RST_STRETCH_MS 1
`define MCPS_RST_STRETCH_CYC (((`MCPS_RST_STRETCH_MS * `MCPS_CYC_PER_MS) > 0) ? \
    (`MCPS_RST_STRETCH_MS * `MCPS_CYC_PER_MS) : 1)
// default input filter window
`define MCPS_DEB_MS 10
`define MCPS_DEB_CYC (`MCPS_DEB_MS * `MCPS_CYC_PER_MS)

// register byte addresses
`define MCPS_ADDR_CTRL 8'h00
`define MCPS_ADDR_STATUS 8'h04
`define MCPS_ADDR_EVENT 8'h08
`define MCPS_ADDR_DEBOUNCE 8'h0C

// control register fields
`define MCPS_CTRL_SHUTDOWN 0
`define MCPS_CTRL_STANDBY 1
`define MCPS_CTRL_AUTO_SLEEP 2

// status register fields
`define MCPS_ST_STATE_LO 0
`define MCPS_ST_FAULT 3
`define MCPS_ST_IO_3V3 4
`define MCPS_ST_STRAP_OK 5
`define MCPS_ST_BUTTON 6
`define MCPS_ST_SLEEP 7
`define MCPS_ST_LID_CLOSED 8
`define MCPS_ST_BAT_LOW 9
`define MCPS_ST_CHARGER 10
`define MCPS_ST_CHARGING 11
`define MCPS_ST_BOOT_SD 12
`define MCPS_ST_STANDBY 13

// event register fields, write one to clear
`define MCPS_EV_BUTTON 0
`define MCPS_EV_BAT_LOW 1
`define MCPS_EV_RESET_IN 2
`define MCPS_EV_WIDTH 3

`define MCPS_CNT_WIDTH 22
`define MCPS_DEB_WIDTH 20
`define MCPS_DEB_LANES 3
`define MCPS_DEB_BUTTON 0
`define MCPS_DEB_SLEEP 1
`define MCPS_DEB_LID 2

`endif

// [logic/mcps_debounce.sv]
// one-bit synchroniser followed by a stable-window filter
// assumes the raw input is idle high and i_len is a cycle count, zero taken as one
`timescale 1ns/10ps
`default_nettype none
`include "mcps_consts.svh"

module mcps_debounce
    import mcps_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_raw,
    input wire logic [`MCPS_DEB_WIDTH-1:0] i_len,
    output logic o_level
);

    mcps_deb_type s_q;
    mcps_deb_type s_d;

    always_comb begin
        s_d = s_q;
        s_d.sync = {s_q.sync[0], i_raw};
        // a change is taken only after the full window without bouncing
        if (s_q.sync[1] == s_q.level) begin
            s_d.cnt = '0;
        end else if ((s_q.cnt + `MCPS_DEB_WIDTH'(1)) >= i_len) begin
            s_d.level = s_q.sync[1];
            s_d.cnt = '0;
        end else begin
            s_d.cnt = s_q.cnt + `MCPS_DEB_WIDTH'(1);
        end
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            // idle lines are pulled high, so start inactive
            s_q <= '{sync: 2'h3, level: 1'b1, cnt: '0};
        end else begin
            s_q <= s_d;
        end
    end

    assign o_level = s_q.level;

endmodule
`default_nettype wire

// [logic/mcps_pkg.sv]
// types shared by the power sequencer and its input filter
// assumes mcps_consts.svh is on the include path
`include "mcps_consts.svh"

package mcps_pkg;

    typedef enum logic [2:0] {
        ST_OFF,
        ST_SUPPLY_UP,
        ST_CARRIER_ON,
        ST_RESET_HOLD,
        ST_RUN
    } mcps_state_type;

    typedef struct packed {
        logic [1:0] sync;
        logic level;
        logic [`MCPS_DEB_WIDTH-1:0] cnt;
    } mcps_deb_type;

    typedef struct packed {
        mcps_state_type st;
        logic [`MCPS_CNT_WIDTH-1:0] cnt;
        logic [1:0] fault_sync;
        logic [1:0] iosel_sync;
        logic [1:0] rstin_sync;
        logic [1:0] bat_sync;
        logic [1:0] chg_sync;
        logic [1:0] chging_sync;
        logic [1:0] boot_sync;
        logic io_3v3;
        logic boot_sd;
        logic standby;
        logic button_prev;
        logic bat_prev;
        logic rstin_prev;
        logic shutdown_req;
        logic standby_req;
        logic auto_sleep;
        logic [`MCPS_EV_WIDTH-1:0] events;
        logic [`MCPS_DEB_WIDTH-1:0] deb_len;
        logic ack;
        logic [31:0] rdata;
    } mcps_regs_type;

endpackage

// [logic/mcps_sequencer.sv]
// power and reset handshake between the compute module and its carrier board
// assumes carrier inputs are open drain, pulled up here, and asynchronous to i_clk;
// i_reset is the module's own power-good reset, asynchronous and active high
//
// Our own choices: the Wishbone register port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
`include "mcps_consts.svh"

module mcps_sequencer
    import mcps_pkg::*;
#(
    parameter bit ONLY_3V3 = 1'b0,
    parameter int unsigned PWR_TO_RST_CYCLES = `MCPS_PWR_TO_RST_CYC,
    parameter int unsigned RST_STRETCH_CYCLES = `MCPS_RST_STRETCH_CYC,
    parameter int unsigned DEBOUNCE_CYCLES = `MCPS_DEB_CYC
)
(
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [7:0] i_wb_adr,
    input wire logic [3:0] i_wb_sel,
    input wire logic [31:0] i_wb_dat,
    output logic [31:0] o_wb_dat,
    output logic o_wb_ack,
    input wire logic i_supply_fault_n,
    input wire logic i_io_sel_n,
    output logic o_io_sel_o,
    output logic o_io_sel_oe_n,
    input wire logic i_module_supply_good,
    output logic o_module_supply_en,
    output logic o_carrier_power_enable,
    output logic o_carrier_reset_n,
    output logic o_module_reset_n,
    input wire logic i_reset_in_n,
    input wire logic i_power_button_n,
    input wire logic i_sleep_n,
    input wire logic i_lid_n,
    input wire logic i_battery_low_n,
    input wire logic i_charger_present_n,
    input wire logic i_charging_n,
    input wire logic i_boot_sel_n,
    output logic o_carrier_standby_n,
    output logic o_boot_from_sd
);

    localparam logic [`MCPS_CNT_WIDTH-1:0] PWR_LAST =
        `MCPS_CNT_WIDTH'(PWR_TO_RST_CYCLES - 1);
    localparam logic [`MCPS_CNT_WIDTH-1:0] STRETCH_LAST =
        `MCPS_CNT_WIDTH'(RST_STRETCH_CYCLES - 1);

    mcps_regs_type s_q;
    mcps_regs_type s_d;
    logic [`MCPS_DEB_LANES-1:0] deb_raw;
    logic [`MCPS_DEB_LANES-1:0] deb_level;

    // byte-lane merge for writable registers
    function automatic logic [31:0] mcps_merge(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0] sel);
        logic [31:0] res;
        res = old_v;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                res[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return res;
    endfunction

    // power may start only with no fault and a strap this variant accepts
    function automatic logic mcps_power_ok(input logic fault_n, input logic strap_n);
        logic ok;
        ok = fault_n;
        if (ONLY_3V3 && !strap_n) begin
            ok = 1'b0;
        end
        return ok;
    endfunction

    assign deb_raw[`MCPS_DEB_BUTTON] = i_power_button_n;
    assign deb_raw[`MCPS_DEB_SLEEP] = i_sleep_n;
    assign deb_raw[`MCPS_DEB_LID] = i_lid_n;

    // button, sleep and lid are mechanical, so they get the window filter
    for (genvar g = 0; g < `MCPS_DEB_LANES; g++) begin : g_deb
        mcps_debounce u_deb (
            .i_clk(i_clk),
            .i_reset(i_reset),
            .i_raw(deb_raw[g]),
            .i_len(s_q.deb_len),
            .o_level(deb_level[g])
        );
    end

    logic fault_n;
    logic strap_n;
    logic rstin_n;
    logic power_ok;
    logic button_on;
    logic sleep_on;
    logic lid_closed;
    logic bat_low;
    logic wb_req;
    logic wb_wr;
    logic [31:0] status_v;
    logic [31:0] ctrl_v;
    logic [31:0] wr_v;
    logic [`MCPS_EV_WIDTH-1:0] ev_set;
    logic [`MCPS_EV_WIDTH-1:0] ev_clr;

    always_comb begin
        s_d = s_q;
        ev_set = '0;
        ev_clr = '0;
        wr_v = '0;

        // only the second stage of each synchroniser is looked at
        s_d.fault_sync = {s_q.fault_sync[0], i_supply_fault_n};
        s_d.iosel_sync = {s_q.iosel_sync[0], i_io_sel_n};
        s_d.rstin_sync = {s_q.rstin_sync[0], i_reset_in_n};
        s_d.bat_sync = {s_q.bat_sync[0], i_battery_low_n};
        s_d.chg_sync = {s_q.chg_sync[0], i_charger_present_n};
        s_d.chging_sync = {s_q.chging_sync[0], i_charging_n};
        s_d.boot_sync = {s_q.boot_sync[0], i_boot_sel_n};

        fault_n = s_q.fault_sync[1];
        strap_n = s_q.iosel_sync[1];
        rstin_n = s_q.rstin_sync[1];
        power_ok = mcps_power_ok(fault_n, strap_n);
        // all carrier inputs are active low
        button_on = ~deb_level[`MCPS_DEB_BUTTON];
        sleep_on = ~deb_level[`MCPS_DEB_SLEEP];
        lid_closed = ~deb_level[`MCPS_DEB_LID];
        bat_low = ~s_q.bat_sync[1];

        // sequencer
        case (s_q.st)
            ST_OFF: begin
                s_d.cnt = '0;
                if (power_ok && !s_q.shutdown_req) begin
                    s_d.st = ST_SUPPLY_UP;
                    s_d.io_3v3 = strap_n;
                end
            end
            ST_SUPPLY_UP: begin
                if (i_module_supply_good) begin
                    s_d.st = ST_CARRIER_ON;
                end
            end
            ST_CARRIER_ON: begin
                // carrier reset stays low while its rails ramp
                if (s_q.cnt >= PWR_LAST) begin
                    s_d.st = ST_RESET_HOLD;
                    s_d.cnt = '0;
                end else begin
                    s_d.cnt = s_q.cnt + `MCPS_CNT_WIDTH'(1);
                end
            end
            ST_RESET_HOLD: begin
                // wait for the carrier's ready, then stretch
                if (!rstin_n) begin
                    s_d.cnt = '0;
                end else if (s_q.cnt >= STRETCH_LAST) begin
                    s_d.st = ST_RUN;
                    s_d.cnt = '0;
                    s_d.boot_sd = ~s_q.boot_sync[1];
                end else begin
                    s_d.cnt = s_q.cnt + `MCPS_CNT_WIDTH'(1);
                end
            end
            ST_RUN: begin
                if (!rstin_n) begin
                    s_d.st = ST_RESET_HOLD;
                    s_d.cnt = '0;
                end
            end
            default: begin
                s_d.st = ST_OFF;
                s_d.cnt = '0;
            end
        endcase

        // fault, bad strap or software shutdown drop every supply at once
        if (s_q.st != ST_OFF && (!power_ok || s_q.shutdown_req)) begin
            s_d.st = ST_OFF;
            s_d.cnt = '0;
        end

        // standby is a run-time state; lid or sleep act only if enabled
        s_d.standby = (s_q.st == ST_RUN) &&
                      (s_q.standby_req || (s_q.auto_sleep && (sleep_on || lid_closed)));

        // events on active edges
        s_d.button_prev = button_on;
        s_d.bat_prev = bat_low;
        s_d.rstin_prev = rstin_n;
        ev_set[`MCPS_EV_BUTTON] = button_on && !s_q.button_prev;
        ev_set[`MCPS_EV_BAT_LOW] = bat_low && !s_q.bat_prev;
        ev_set[`MCPS_EV_RESET_IN] = !rstin_n && s_q.rstin_prev;

        // register view
        status_v = '0;
        status_v[`MCPS_ST_STATE_LO +: 3] = s_q.st;
        status_v[`MCPS_ST_FAULT] = ~fault_n;
        status_v[`MCPS_ST_IO_3V3] = s_q.io_3v3;
        status_v[`MCPS_ST_STRAP_OK] = power_ok;
        status_v[`MCPS_ST_BUTTON] = button_on;
        status_v[`MCPS_ST_SLEEP] = sleep_on;
        status_v[`MCPS_ST_LID_CLOSED] = lid_closed;
        status_v[`MCPS_ST_BAT_LOW] = bat_low;
        status_v[`MCPS_ST_CHARGER] = ~s_q.chg_sync[1];
        status_v[`MCPS_ST_CHARGING] = ~s_q.chging_sync[1];
        status_v[`MCPS_ST_BOOT_SD] = s_q.boot_sd;
        status_v[`MCPS_ST_STANDBY] = s_q.standby;
        ctrl_v = '0;
        ctrl_v[`MCPS_CTRL_SHUTDOWN] = s_q.shutdown_req;
        ctrl_v[`MCPS_CTRL_STANDBY] = s_q.standby_req;
        ctrl_v[`MCPS_CTRL_AUTO_SLEEP] = s_q.auto_sleep;

        // classic Wishbone: one wait state, ack drops the cycle after
        wb_req = i_wb_cyc && i_wb_stb && !s_q.ack;
        wb_wr = wb_req && i_wb_we;
        s_d.ack = wb_req;
        if (wb_req) begin
            case (i_wb_adr)
                `MCPS_ADDR_CTRL: s_d.rdata = ctrl_v;
                `MCPS_ADDR_STATUS: s_d.rdata = status_v;
                `MCPS_ADDR_EVENT: s_d.rdata = 32'(s_q.events);
                `MCPS_ADDR_DEBOUNCE: s_d.rdata = 32'(s_q.deb_len);
                default: s_d.rdata = '0;
            endcase
        end
        if (wb_wr) begin
            case (i_wb_adr)
                `MCPS_ADDR_CTRL: begin
                    wr_v = mcps_merge(ctrl_v, i_wb_dat, i_wb_sel);
                    s_d.shutdown_req = wr_v[`MCPS_CTRL_SHUTDOWN];
                    s_d.standby_req = wr_v[`MCPS_CTRL_STANDBY];
                    s_d.auto_sleep = wr_v[`MCPS_CTRL_AUTO_SLEEP];
                end
                `MCPS_ADDR_EVENT: begin
                    if (i_wb_sel[0]) begin
                        ev_clr = i_wb_dat[`MCPS_EV_WIDTH-1:0];
                    end
                end
                `MCPS_ADDR_DEBOUNCE: begin
                    wr_v = mcps_merge(32'(s_q.deb_len), i_wb_dat, i_wb_sel);
                    s_d.deb_len = wr_v[`MCPS_DEB_WIDTH-1:0];
                end
                default: begin
                    wr_v = '0;
                end
            endcase
        end
        // a new event beats a clear in the same cycle
        s_d.events = (s_q.events & ~ev_clr) | ev_set;
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            s_q <= '{
                st: ST_OFF,
                cnt: '0,
                fault_sync: 2'h0,
                iosel_sync: 2'h3,
                rstin_sync: 2'h0,
                bat_sync: 2'h3,
                chg_sync: 2'h3,
                chging_sync: 2'h3,
                boot_sync: 2'h3,
                io_3v3: 1'b1,
                boot_sd: 1'b0,
                standby: 1'b0,
                button_prev: 1'b0,
                bat_prev: 1'b0,
                rstin_prev: 1'b0,
                shutdown_req: 1'b0,
                standby_req: 1'b0,
                auto_sleep: 1'b0,
                events: '0,
                deb_len: `MCPS_DEB_WIDTH'(DEBOUNCE_CYCLES),
                ack: 1'b0,
                rdata: '0
            };
        end else begin
            s_q <= s_d;
        end
    end

    // outputs decode the registered state only
    assign o_module_supply_en = (s_q.st != ST_OFF);
    // carrier side stays dark until here; its own side relies on this
    assign o_carrier_power_enable = (s_q.st == ST_CARRIER_ON) ||
                                    (s_q.st == ST_RESET_HOLD) ||
                                    (s_q.st == ST_RUN);
    assign o_carrier_reset_n = (s_q.st == ST_RUN);
    assign o_module_reset_n = (s_q.st == ST_RUN);
    // select line is driven to the decoded level once the carrier is enabled
    assign o_io_sel_o = s_q.io_3v3;
    assign o_io_sel_oe_n = ~o_carrier_power_enable;
    assign o_carrier_standby_n = ~s_q.standby;
    assign o_boot_from_sd = s_q.boot_sd;
    assign o_wb_dat = s_q.rdata;
    assign o_wb_ack = s_q.ack;

endmodule
`default_nettype wire

// [sim/mcps_carrier_model.sv]
// carrier board model: open-drain control lines, supply ramp, power-good reset
// assumes the bench steers fault, strap, reset request and carrier speed
`timescale 1ns/10ps
`default_nettype none

module mcps_carrier_model (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_carrier_power_enable,
    input wire logic i_module_supply_en,
    input wire logic i_io_sel_o,
    input wire logic i_io_sel_oe_n,
    input wire logic i_fault_low,
    input wire logic i_strap_low,
    input wire logic i_reset_low,
    input wire logic i_slow,
    output logic o_supply_fault_n,
    output logic o_io_sel_n,
    output logic o_module_supply_good,
    output logic o_reset_in_n
);
    typedef struct packed {
        logic [7:0] ready;
        logic [1:0] ramp;
    } mcps_car_type;
    mcps_car_type r_q;
    mcps_car_type r_d;

    always_comb begin
        r_d = r_q;
        // main carrier rails ramp only while the module enables them
        r_d.ready = !i_carrier_power_enable ? 8'h00 : r_q.ready + 8'(r_q.ready != 8'hFF);
        r_d.ramp = !i_module_supply_en ? 2'h0 : r_q.ramp + 2'(r_q.ramp != 2'h3);
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            r_q <= '0;
        end else begin
            r_q <= r_d;
        end
    end

    // fault and reset lines are only floated or grounded; the pull-up makes released lines high
    assign o_supply_fault_n = !i_fault_low;
    // a grounded strap wins over the module's own drive
    assign o_io_sel_n = i_strap_low ? 1'b0 : (i_io_sel_oe_n ? 1'b1 : i_io_sel_o);
    assign o_module_supply_good = (r_q.ramp == 2'h3);
    // released as carrier power good, grounded to force a reset
    assign o_reset_in_n = !i_reset_low && (r_q.ready >= (i_slow ? 8'hC8 : 8'h14));
endmodule
`default_nettype wire

// [sim/mcps_seq_sva.sv]
// assertion checker on the power sequencer ports, bound into the design
// assumes one clock domain and an asynchronous active-high reset
`timescale 1ns/10ps
`default_nettype none

module mcps_seq_sva #(
    parameter int unsigned PWR_TO_RST_CYCLES = 50,
    parameter int unsigned RST_STRETCH_CYCLES = 10
)
(
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic o_wb_ack,
    input wire logic i_supply_fault_n,
    input wire logic i_module_supply_good,
    input wire logic o_module_supply_en,
    input wire logic o_carrier_power_enable,
    input wire logic o_io_sel_oe_n,
    input wire logic o_carrier_reset_n,
    input wire logic o_module_reset_n,
    input wire logic i_reset_in_n,
    input wire logic o_carrier_standby_n,
    input wire logic o_boot_from_sd
);
    localparam int unsigned CAP = 4000000;
    int unsigned en_cnt_q;
    int unsigned hi_cnt_q;

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_reset);

    // saturating, so a long run never wraps back under the limit
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            en_cnt_q <= 0;
            hi_cnt_q <= 0;
        end else begin
            en_cnt_q <= !o_carrier_power_enable ? 0 : en_cnt_q + 32'(en_cnt_q < CAP);
            hi_cnt_q <= !i_reset_in_n ? 0 : hi_cnt_q + 32'(hi_cnt_q < CAP);
        end
    end

    sequence s_fault_low3;
        !i_supply_fault_n [*3];
    endsequence
    sequence s_rstin_low3;
        !i_reset_in_n [*3];
    endsequence
    sequence s_req_taken;
        i_wb_cyc && i_wb_stb && !o_wb_ack;
    endsequence

    a_fault_off: assert property (s_fault_low3 |=>
        !o_module_supply_en && !o_carrier_power_enable) else $error("supply on in fault");
    a_good_first: assert property ($rose(o_carrier_power_enable) |->
        $past(i_module_supply_good)) else $error("carrier enable before supply good");
    a_enable_pair: assert property (o_carrier_power_enable |->
        o_module_supply_en && !o_io_sel_oe_n) else $error("enable without io select");
    a_reset_gate: assert property (!o_carrier_power_enable |->
        !o_carrier_reset_n && !o_module_reset_n) else $error("reset released unpowered");
    a_release_wait: assert property ($rose(o_carrier_reset_n) |->
        en_cnt_q >= PWR_TO_RST_CYCLES) else $error("carrier reset released early");
    a_rstin_hold: assert property (s_rstin_low3 |=>
        !o_module_reset_n && !o_carrier_reset_n) else $error("reset input ignored");
    a_reset_stretch: assert property ($rose(o_module_reset_n) |->
        hi_cnt_q >= RST_STRETCH_CYCLES) else $error("reset stretch too short");
    a_standby_run: assert property (!o_carrier_standby_n |->
        $past(o_module_reset_n)) else $error("standby outside run");
    a_boot_latch: assert property (!$stable(o_boot_from_sd) |->
        $rose(o_module_reset_n)) else $error("boot source moved outside boot");
    a_ack_answer: assert property (s_req_taken |=> o_wb_ack)
        else $error("bus request not answered");
    a_ack_pulse: assert property (o_wb_ack |=> !o_wb_ack)
        else $error("ack longer than one cycle");
endmodule

bind mcps_sequencer mcps_seq_sva #(
    .PWR_TO_RST_CYCLES(PWR_TO_RST_CYCLES), .RST_STRETCH_CYCLES(RST_STRETCH_CYCLES)
) u_sva (
    .i_clk(i_clk), .i_reset(i_reset), .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb),
    .o_wb_ack(o_wb_ack), .i_supply_fault_n(i_supply_fault_n),
    .i_module_supply_good(i_module_supply_good), .o_module_supply_en(o_module_supply_en),
    .o_carrier_power_enable(o_carrier_power_enable), .o_io_sel_oe_n(o_io_sel_oe_n),
    .o_carrier_reset_n(o_carrier_reset_n), .o_module_reset_n(o_module_reset_n),
    .i_reset_in_n(i_reset_in_n), .o_carrier_standby_n(o_carrier_standby_n),
    .o_boot_from_sd(o_boot_from_sd)
);
`default_nettype wire

// [sim/tb_mcps_sequencer.sv]
// self-checking bench: register port tasks plus a carrier model
// assumes shortened counts and the one-wait-state register port
`timescale 1ns/10ps
`default_nettype none

module tb_mcps_sequencer;
    logic i_clk = 1'b0;
    logic i_reset = 1'b1;
    logic wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0;
    logic [7:0] wb_adr = 8'h00;
    logic [31:0] wb_dat = 32'h0;
    logic fault_low = 1'b1, strap_low = 1'b1, rst_low = 1'b0, slow = 1'b0;
    logic [2:0] deb_n = 3'h7;
    logic [2:0] pm_n = 3'h7;
    logic boot_n = 1'b0; // sd boot: boot select held low
    wire [31:0] wb_rdat;
    wire wb_ack, io_sel_o, io_sel_oe_n, supply_en, pwr_en, car_rst_n, mod_rst_n;
    wire stby_n, boot_sd, fault_n, io_sel_n, good, rstin_n;
    int checks = 0;
    int err_total = 0;
    int i;

    always #20 i_clk = ~i_clk;

    mcps_sequencer #(.ONLY_3V3(1'b0), .PWR_TO_RST_CYCLES(50), .RST_STRETCH_CYCLES(10),
        .DEBOUNCE_CYCLES(4)) uut (
        .i_clk(i_clk), .i_reset(i_reset), .i_wb_cyc(wb_cyc), .i_wb_stb(wb_stb),
        .i_wb_we(wb_we), .i_wb_adr(wb_adr), .i_wb_sel(4'hF), .i_wb_dat(wb_dat),
        .o_wb_dat(wb_rdat), .o_wb_ack(wb_ack), .i_supply_fault_n(fault_n),
        .i_io_sel_n(io_sel_n), .o_io_sel_o(io_sel_o), .o_io_sel_oe_n(io_sel_oe_n),
        .i_module_supply_good(good), .o_module_supply_en(supply_en),
        .o_carrier_power_enable(pwr_en), .o_carrier_reset_n(car_rst_n),
        .o_module_reset_n(mod_rst_n), .i_reset_in_n(rstin_n),
        .i_power_button_n(deb_n[0]), .i_sleep_n(deb_n[1]), .i_lid_n(deb_n[2]),
        .i_battery_low_n(pm_n[0]), .i_charger_present_n(pm_n[1]),
        .i_charging_n(pm_n[2]), .i_boot_sel_n(boot_n),
        .o_carrier_standby_n(stby_n), .o_boot_from_sd(boot_sd));

    mcps_carrier_model u_car (.i_clk(i_clk), .i_reset(i_reset),
        .i_carrier_power_enable(pwr_en), .i_module_supply_en(supply_en),
        .i_io_sel_o(io_sel_o), .i_io_sel_oe_n(io_sel_oe_n), .i_fault_low(fault_low),
        .i_strap_low(strap_low), .i_reset_low(rst_low), .i_slow(slow),
        .o_supply_fault_n(fault_n), .o_io_sel_n(io_sel_n),
        .o_module_supply_good(good), .o_reset_in_n(rstin_n));

    task automatic results();
        $display("checks=%0d err_total=%0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic hang();
        err_total++;
        $display("BAD t=%0t got=%h exp=%h", $time, 32'h0, 32'h1);
        results();
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk1(input logic got, input logic exp);
        chk({31'h0, got}, {31'h0, exp});
    endtask

    // classic cycle: hold everything until ack is seen, release at that edge
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
            output logic [31:0] q);
        int n;
        @(posedge i_clk);
        {wb_cyc, wb_stb, wb_we, wb_adr, wb_dat} <= {1'b1, 1'b1, w, a, d};
        n = 0;
        @(negedge i_clk);
        while (wb_ack !== 1'b1 && n < 20) begin
            @(negedge i_clk);
            n++;
        end
        if (n == 20) hang();
        @(posedge i_clk);
        q = wb_rdat;
        {wb_cyc, wb_stb, wb_we} <= 3'h0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        wb(1'b1, a, d, q);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        logic [31:0] q;
        wb(1'b0, a, 32'h0, q);
        chk(q & m, e);
    endtask

    // polls the state field; the bound covers the slow carrier too
    task automatic wait_state(input logic [2:0] s);
        logic [31:0] q;
        int n;
        for (n = 0; n < 300; n++) begin
            wb(1'b0, 8'h04, 32'h0, q);
            if (q[2:0] === s) break;
        end
        if (n == 300) hang();
    endtask

    initial begin
        repeat (12) @(posedge i_clk);
        i_reset <= 1'b0;
        rd(8'h00, 32'hFFFFFFFF, 32'h0);
        rd(8'h0C, 32'h000FFFFF, 32'h4);
        rd(8'h10, 32'hFFFFFFFF, 32'h0);
        repeat (20) @(posedge i_clk);
        @(negedge i_clk);
        chk1(supply_en, 1'b0);
        chk1(pwr_en, 1'b0);
        chk1(stby_n, 1'b1);
        $display("test fault hold done");
        @(posedge i_clk) fault_low <= 1'b0;
        wait_state(3'h4);
        rd(8'h04, 32'h0000103F, 32'h00001024);
        @(negedge i_clk);
        chk1(boot_sd, 1'b1);
        chk1(io_sel_o, 1'b0);
        chk1(car_rst_n, 1'b1);
        $display("test power up done");
        wr(8'h08, 32'h7);
        rd(8'h08, 32'h7, 32'h0);
        // a single low sample must still give the full reset
        @(posedge i_clk) rst_low <= 1'b1;
        @(posedge i_clk) rst_low <= 1'b0;
        repeat (8) @(posedge i_clk);
        @(negedge i_clk);
        chk1(mod_rst_n, 1'b0);
        chk1(car_rst_n, 1'b0);
        wait_state(3'h4);
        rd(8'h08, 32'h7, 32'h4);
        wr(8'h08, 32'h4);
        rd(8'h08, 32'h7, 32'h0);
        $display("test reset input done");
        wr(8'h0C, 32'h8);
        rd(8'h0C, 32'h000FFFFF, 32'h8);
        @(posedge i_clk) deb_n[0] <= 1'b0;
        repeat (5) @(posedge i_clk);
        deb_n[0] <= 1'b1;
        repeat (20) @(posedge i_clk);
        rd(8'h08, 32'h1, 32'h0);
        @(posedge i_clk) deb_n[0] <= 1'b0;
        repeat (20) @(posedge i_clk);
        rd(8'h04, 32'h40, 32'h40);
        deb_n[0] <= 1'b1;
        rd(8'h08, 32'h1, 32'h1);
        $display("test button done");
        @(posedge i_clk) pm_n <= 3'h0;
        repeat (4) @(posedge i_clk);
        rd(8'h04, 32'h0E00, 32'h0E00);
        rd(8'h08, 32'h2, 32'h2);
        pm_n <= 3'h7;
        repeat (4) @(posedge i_clk);
        rd(8'h04, 32'h0E00, 32'h0);
        $display("test battery done");
        wr(8'h00, 32'h2);
        @(negedge i_clk);
        chk1(stby_n, 1'b0);
        wr(8'h00, 32'h4);
        @(negedge i_clk);
        chk1(stby_n, 1'b1);
        for (i = 1; i < 3; i++) begin
            @(posedge i_clk) deb_n[i] <= 1'b0;
            repeat (20) @(posedge i_clk);
            rd(8'h04, 32'h2180, (i == 1) ? 32'h2080 : 32'h2100);
            @(negedge i_clk);
            chk1(stby_n, 1'b0);
            @(posedge i_clk) deb_n[i] <= 1'b1;
            repeat (20) @(posedge i_clk);
            @(negedge i_clk);
            chk1(stby_n, 1'b1);
        end
        $display("test standby done");
        wr(8'h00, 32'h0);
        @(posedge i_clk) {fault_low, strap_low, boot_n} <= 3'b101;
        repeat (4) @(posedge i_clk);
        @(negedge i_clk);
        chk1(supply_en, 1'b0);
        chk1(pwr_en, 1'b0);
        @(posedge i_clk) fault_low <= 1'b0;
        wait_state(3'h4);
        rd(8'h04, 32'h1030, 32'h0030);
        @(negedge i_clk);
        chk1(boot_sd, 1'b0);
        chk1(io_sel_o, 1'b1);
        $display("test fault in run done");
        wr(8'h00, 32'h1);
        wait_state(3'h0);
        @(negedge i_clk);
        chk1(pwr_en, 1'b0);
        @(posedge i_clk) slow <= 1'b1;
        wr(8'h00, 32'h0);
        wait_state(3'h3);
        @(negedge i_clk);
        chk1(mod_rst_n, 1'b0);
        wait_state(3'h4);
        $display("test slow carrier done");
        results();
    end
endmodule
`default_nettype wire
